// >>> common/mes_if.sv
// Interface joining the MAC event block and its software-side end
interface mes_if;
	logic [31:0] wr_data;
	logic wr_en;
	logic [31:0] status;
	logic [31:0] enable_wr;
	logic enable_we;
	logic [31:0] enable;
	logic start_demand;
	logic tx_irq;
	logic rx_irq;
	modport dev (
		input wr_data, wr_en, enable_wr, enable_we, start_demand,
		output status, enable, tx_irq, rx_irq
	);
	modport host (
		output wr_data, wr_en, enable_wr, enable_we, start_demand,
		input status, enable, tx_irq, rx_irq
	);
endinterface

// >>> common/mes_pkg.sv
// Package of bit positions, reset values and codes for the MAC event status block
package mes_pkg;
	localparam int unsigned DATA_W = 32;
	// Status bit positions
	localparam int unsigned BIT_RX_SUM = 0;
	localparam int unsigned BIT_ALIGN = 5;
	localparam int unsigned BIT_RUNT = 6;
	localparam int unsigned BIT_MISSED = 7;
	localparam int unsigned BIT_MAX_LEN = 8;
	localparam int unsigned BIT_EARLY = 9;
	localparam int unsigned BIT_DESC = 10;
	localparam int unsigned BIT_BUS_ERR = 11;
	localparam int unsigned BIT_PAUSE = 14;
	localparam int unsigned BIT_TX_SUM = 16;
	localparam int unsigned BIT_TX_UNDER = 17;
	// Summary source ranges
	localparam logic [31:0] RX_SRC_MASK = 32'h0000_7ffe;
	localparam logic [31:0] TX_SRC_MASK = 32'h01fe_0000;
	// Flags implemented by this block
	localparam logic [31:0] FLAG_MASK = 32'h0002_4fe0;
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
	// Shortest legal frame in bytes
	localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
	// Missed packet counter width
	localparam int unsigned MISS_W = 16;
	// Receive DMA states
	typedef enum logic [1:0] {
		MES_DMA_RUN = 2'b01,
		MES_DMA_HALT = 2'b10
	} mes_dma_t;
endpackage

// >>> core/mes_device.sv
// Event status latch and interrupt summary of the MAC
// What this block does; RULE_02 and RULE_09 are duties of software
// [RULE_01] Set bit 17 on underflow; retransmit packet
// [RULE_02] Software raises threshold on frequent underflow
// [RULE_03] Flags stay set until written one
// [RULE_04] Bit 16 ORs enabled flags 17-24
// [RULE_05] Transmit interrupt needs summary and enable
// [RULE_06] Enabled underflow flag raises transmit summary
// [RULE_07] Bit 14 on pause frame, full duplex
// [RULE_08] Bit 11 on receive DMA bus error
// [RULE_09] Software resets MAC on bus error
// [RULE_10] Bit 10 and halt without descriptor
// [RULE_11] Start demand releases halted receive DMA
// [RULE_12] Bit 9 once length/type field arrives
// [RULE_13] Drop oversize frame, set bit 8
// [RULE_14] Bit 7 on missed counter rollover
// [RULE_15] Drop frame under 64 bytes, bit 6
// [RULE_16] Accept-runt keeps short frames, no flag
// [RULE_17] Bit 5 on non-byte frame length
// [RULE_18] Enabled receive flags raise receive summary
// [RULE_19] Bit 0 ORs enabled flags 1-14
// [RULE_20] Zero write keeps bit; set beats clear
module mes_device (
	input wire logic clk_sys,
	input wire logic rst_n,
	mes_if.dev bus,
	input wire logic tx_underflow,
	input wire logic pause_frame_rx,
	input wire logic full_duplex,
	input wire logic rx_dma_bus_error,
	input wire logic rx_desc_empty,
	input wire logic rx_len_type_seen,
	input wire logic missed_packet,
	input wire logic frame_end,
	input wire logic [15:0] frame_len,
	input wire logic frame_odd_bits,
	input wire logic [15:0] rx_max_frame_len,
	input wire logic accept_runt_enable,
	output logic tx_retransmit,
	output logic rx_frame_drop,
	output logic rx_dma_halted,
	output logic [mes_pkg::MISS_W-1:0] missed_packet_counter
);
	logic [31:0] flags_q, flags_d; // Sticky event flags
	logic [31:0] enable_q, enable_d; // Per-bit enables, bits 0 and 16 gate the outputs
	logic [31:0] set_vec; // Events this cycle
	logic [31:0] view; // Status as software sees it
	logic tx_sum, rx_sum;
	logic retx_q, retx_d;
	mes_pkg::mes_dma_t dma_q, dma_d;
	logic [mes_pkg::MISS_W-1:0] miss_q, miss_d;
	logic miss_wrap;
	logic runt_ev, long_ev, align_ev, drop_ev;

	// Length, runt and alignment checks live in their own small unit
	mes_frame_check u_check (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.frame_end(frame_end),
		.frame_len(frame_len),
		.frame_odd_bits(frame_odd_bits),
		.max_len(rx_max_frame_len),
		.accept_runt_enable(accept_runt_enable),
		.runt_ev(runt_ev),
		.max_len_ev(long_ev),
		.align_ev(align_ev),
		.frame_drop(drop_ev)
	);

	// OR of enabled flags over a source range
	function automatic logic summary(input logic [31:0] f, input logic [31:0] e,
		input logic [31:0] m);
		summary = |(f & e & m);
	endfunction

	// Missed packet counter; the wrap is the carry out of its top bit
	always_comb begin
		miss_d = miss_q;
		miss_wrap = 1'b0;
		if (missed_packet) begin
			miss_d = miss_q + 1'b1;
			miss_wrap = &miss_q; // [RULE_14]
		end
	end

	// Collect this cycle's events into status bit positions
	always_comb begin
		set_vec = 32'h0000_0000;
		set_vec[mes_pkg::BIT_TX_UNDER] = tx_underflow; // [RULE_01]
		set_vec[mes_pkg::BIT_PAUSE] = pause_frame_rx && full_duplex; // [RULE_07]
		set_vec[mes_pkg::BIT_BUS_ERR] = rx_dma_bus_error; // [RULE_08]
		set_vec[mes_pkg::BIT_DESC] = rx_desc_empty && (dma_q == mes_pkg::MES_DMA_RUN); // [RULE_10]
		set_vec[mes_pkg::BIT_EARLY] = rx_len_type_seen; // [RULE_12]
		set_vec[mes_pkg::BIT_MAX_LEN] = long_ev; // [RULE_13]
		set_vec[mes_pkg::BIT_MISSED] = miss_wrap; // [RULE_14]
		set_vec[mes_pkg::BIT_RUNT] = runt_ev; // [RULE_15]
		set_vec[mes_pkg::BIT_ALIGN] = align_ev; // [RULE_17]
	end

	// Write-one-to-clear; a fresh event in the same cycle wins
	always_comb begin
		flags_d = flags_q;
		if (bus.wr_en) begin
			flags_d = flags_q & ~bus.wr_data; // [RULE_03] [RULE_20]
		end
		flags_d = (flags_d | set_vec) & mes_pkg::FLAG_MASK; // [RULE_20]
		enable_d = bus.enable_we ? bus.enable_wr : enable_q;
	end

	// Receive DMA halts on a missing descriptor until start demand
	always_comb begin
		dma_d = dma_q;
		unique case (dma_q)
			mes_pkg::MES_DMA_RUN: begin
				if (rx_desc_empty) begin
					dma_d = mes_pkg::MES_DMA_HALT; // [RULE_10]
				end
			end
			mes_pkg::MES_DMA_HALT: begin
				if (bus.start_demand) begin
					dma_d = mes_pkg::MES_DMA_RUN; // [RULE_11]
				end
			end
			default: begin
				dma_d = mes_pkg::MES_DMA_HALT;
			end
		endcase
	end

	// Retransmit request follows an underflow without software help
	always_comb begin
		retx_d = tx_underflow; // [RULE_01]
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flags_q <= mes_pkg::STATUS_RST;
			enable_q <= mes_pkg::ENABLE_RST;
			dma_q <= mes_pkg::MES_DMA_RUN;
			miss_q <= '0;
			retx_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			enable_q <= enable_d;
			dma_q <= dma_d;
			miss_q <= miss_d;
			retx_q <= retx_d;
		end
	end

	// Summaries are pure logic on the stored flags, so clearing flags clears them
	always_comb begin
		tx_sum = summary(flags_q, enable_q, mes_pkg::TX_SRC_MASK); // [RULE_04] [RULE_06]
		rx_sum = summary(flags_q, enable_q, mes_pkg::RX_SRC_MASK); // [RULE_18] [RULE_19]
		view = flags_q;
		view[mes_pkg::BIT_TX_SUM] = tx_sum; // [RULE_04]
		view[mes_pkg::BIT_RX_SUM] = rx_sum; // [RULE_19]
	end

	assign bus.status = view;
	assign bus.enable = enable_q;
	assign bus.tx_irq = tx_sum && enable_q[mes_pkg::BIT_TX_SUM]; // [RULE_05]
	assign bus.rx_irq = rx_sum && enable_q[mes_pkg::BIT_RX_SUM];
	assign tx_retransmit = retx_q;
	assign rx_frame_drop = drop_ev;
	assign rx_dma_halted = (dma_q == mes_pkg::MES_DMA_HALT);
	assign missed_packet_counter = miss_q;
endmodule

// >>> core/mes_frame_check.sv
// Received frame classifier for length, runt and alignment checks
module mes_frame_check (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic frame_end,
	input wire logic [15:0] frame_len,
	input wire logic frame_odd_bits,
	input wire logic [15:0] max_len,
	input wire logic accept_runt_enable,
	output logic runt_ev,
	output logic max_len_ev,
	output logic align_ev,
	output logic frame_drop
);
	logic runt_d, runt_q, long_d, long_q, align_d, align_q, drop_d, drop_q;

	// Classify at the frame end strobe
	always_comb begin
		long_d = frame_end && (frame_len > max_len); // [RULE_13]
		runt_d = frame_end && (frame_len < mes_pkg::MIN_FRAME_BYTES) && !accept_runt_enable; // [RULE_15] [RULE_16]
		align_d = frame_end && frame_odd_bits; // [RULE_17]
		drop_d = long_d || runt_d; // [RULE_13] [RULE_15]
	end

	// Register the one-cycle event pulses
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			runt_q <= 1'b0;
			long_q <= 1'b0;
			align_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			runt_q <= runt_d;
			long_q <= long_d;
			align_q <= align_d;
			drop_q <= drop_d;
		end
	end

	assign runt_ev = runt_q;
	assign max_len_ev = long_q;
	assign align_ev = align_q;
	assign frame_drop = drop_q;
endmodule

// >>> core/mes_host.sv
// Software-side end: clears flags, loads enables, issues start demand
module mes_host (
	input wire logic clk_sys,
	input wire logic rst_n,
	mes_if.host bus,
	input wire logic clear_req,
	input wire logic [31:0] clear_bits,
	input wire logic enable_req,
	input wire logic [31:0] enable_bits,
	input wire logic demand_req,
	output logic [31:0] status_seen,
	output logic tx_irq_seen,
	output logic rx_irq_seen,
	output logic bus_error_seen
);
	logic [31:0] wd_q, wd_d, ew_q, ew_d, st_q, st_d;
	logic we_q, we_d, ee_q, ee_d, sd_q, sd_d;

	// Drive one-cycle requests from the user side
	always_comb begin
		we_d = clear_req; // [RULE_03]
		wd_d = clear_req ? clear_bits : 32'h0000_0000;
		ee_d = enable_req;
		ew_d = enable_req ? enable_bits : ew_q;
		sd_d = demand_req; // [RULE_11]
		st_d = bus.status;
	end

	// Register requests and sampled status
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wd_q <= 32'h0000_0000;
			we_q <= 1'b0;
			ew_q <= 32'h0000_0000;
			ee_q <= 1'b0;
			sd_q <= 1'b0;
			st_q <= 32'h0000_0000;
		end else begin
			wd_q <= wd_d;
			we_q <= we_d;
			ew_q <= ew_d;
			ee_q <= ee_d;
			sd_q <= sd_d;
			st_q <= st_d;
		end
	end

	assign bus.wr_data = wd_q;
	assign bus.wr_en = we_q;
	assign bus.enable_wr = ew_q;
	assign bus.enable_we = ee_q;
	assign bus.start_demand = sd_q;
	assign status_seen = st_q;
	assign tx_irq_seen = bus.tx_irq;
	assign rx_irq_seen = bus.rx_irq;
	// Bus error tells software a MAC reset is advisable
	assign bus_error_seen = st_q[mes_pkg::BIT_BUS_ERR]; // [RULE_09]
endmodule

// >>> verif/mac_event_status_irq_tb_top.sv
// Random testbench joining the event block to its software end
module mac_event_status_irq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, tx_u, pause, fdx, berr, dempty, ltype, missed, fend, odd, arun;
	logic [15:0] flen, fmax;
	logic creq, ereq, dreq, chk, halted, retx, drop, berr_seen, txi_seen, rxi_seen;
	logic [31:0] cbits, ebits, st, en, st_seen;
	logic [15:0] mcnt, mc; // Missed counter seen and expected
	logic hm; // Expected receive DMA halt
	logic rt, dp; // Expected retransmit and drop pulses
	logic [1:0] pl; // Drop and retransmit pulses seen since the last compare
	logic [87:0] q[$]; // Expected notes, oldest first
	int errors, checks_done;
	mes_if bus ();
	mes_device mes_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.dev), .tx_underflow(tx_u),
		.pause_frame_rx(pause), .full_duplex(fdx), .rx_dma_bus_error(berr), .rx_desc_empty(dempty),
		.rx_len_type_seen(ltype), .missed_packet(missed), .frame_end(fend), .frame_len(flen),
		.frame_odd_bits(odd), .rx_max_frame_len(fmax), .accept_runt_enable(arun),
		.tx_retransmit(retx), .rx_frame_drop(drop), .rx_dma_halted(halted),
		.missed_packet_counter(mcnt));
	mes_host mes_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.host), .clear_req(creq),
		.clear_bits(cbits), .enable_req(ereq), .enable_bits(ebits), .demand_req(dreq),
		.status_seen(st_seen), .tx_irq_seen(txi_seen), .rx_irq_seen(rxi_seen),
		.bus_error_seen(berr_seen));
	mes_irq_props mes_irq_props_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wr_data(bus.wr_data),
		.wr_en(bus.wr_en), .status(bus.status), .enable_wr(bus.enable_wr), .enable_we(bus.enable_we),
		.enable(bus.enable), .tx_irq(bus.tx_irq), .rx_irq(bus.rx_irq));
	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic check(string nm, logic [87:0] seen, logic [87:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Queue the expected word and flag the monitor for one cycle
	task automatic note;
		logic [31:0] s;
		logic ri, ti;
		s = st & mes_pkg::FLAG_MASK;
		s[0] = |(s & en & mes_pkg::RX_SRC_MASK);
		s[16] = |(s & en & mes_pkg::TX_SRC_MASK);
		ri = s[0] & en[0];
		ti = s[16] & en[16];
		// Host copies: status one cycle late, bus error bit, interrupt lines
		q.push_back({mc, dp, rt, s[11], ri, ti, hm, ri, ti, s, s});
		chk <= 1'b1;
		@(negedge clk_sys);
		chk <= 1'b0;
	endtask
	// Monitor: compares at the falling edge, after the rising edge has settled
	// Pulse outputs stand one cycle only, so they are gathered until the next compare
	always @(negedge clk_sys) begin
		logic [87:0] seen;
		seen = {mcnt, pl, berr_seen, rxi_seen, txi_seen, halted, bus.rx_irq, bus.tx_irq,
			st_seen, bus.status};
		if (chk) begin
			check("event_view", seen, q.pop_front());
			pl = 2'b00;
		end
		pl = rst_n ? (pl | {drop, retx}) : 2'b00;
	end
	// Main sequence: a counter wrap, then random clears, enables and events
	initial begin
		int k;
		{rst_n, tx_u, pause, fdx, berr, dempty, ltype, missed, fend, odd, arun} = '0;
		{creq, ereq, dreq, chk, hm, rt, dp} = '0;
		{flen, fmax, mc, cbits, ebits, st, en} = '0;
		void'($urandom(99980));
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		missed = 1'b1;
		repeat (65536) @(negedge clk_sys);
		missed = 1'b0;
		st[7] = 1'b1;
		repeat (2) @(negedge clk_sys);
		note();
		for (int i = 0; i < 300; i++) begin
			k = $urandom_range(6, 0);
			cbits = $urandom;
			ebits = $urandom;
			creq = 1'b1;
			ereq = 1'b1;
			dreq = (k != 4) && ($urandom_range(1, 0) == 1);
			@(negedge clk_sys);
			// Events land on the same edge as the clear, frame check events one edge later, so set must win
			st = st & ~cbits;
			en = ebits;
			if (dreq) hm = 1'b0;
			{creq, ereq, dreq, rt, dp} = '0;
			case (k)
				// Underflow stays one event in several, so no threshold raise is due
				0: begin tx_u = 1'b1; st[17] = 1'b1; rt = 1'b1; end
				1: begin
					fdx = 1'($urandom_range(1, 0));
					pause = 1'b1;
					if (fdx) st[14] = 1'b1;
				end
				2: begin berr = 1'b1; st[11] = 1'b1; end
				3: begin ltype = 1'b1; st[9] = 1'b1; end
				4: begin
					dempty = 1'b1;
					if (!hm) st[10] = 1'b1;
					hm = 1'b1;
				end
				6: begin missed = 1'b1; mc = mc + 16'h0001; end
				default: begin
					flen = 16'($urandom_range(127, 0));
					fmax = 16'($urandom_range(100, 60));
					odd = 1'($urandom_range(1, 0));
					arun = 1'($urandom_range(1, 0));
					fend = 1'b1;
					if (odd) st[5] = 1'b1;
					// Runt and oversize frames are dropped as well as flagged
					if (flen < mes_pkg::MIN_FRAME_BYTES && !arun) begin
						st[6] = 1'b1;
						dp = 1'b1;
					end
					if (flen > fmax) begin
						st[8] = 1'b1;
						dp = 1'b1;
					end
				end
			endcase
			@(negedge clk_sys);
			{tx_u, pause, berr, ltype, dempty, fend, missed} = '0;
			@(negedge clk_sys);
			note();
		end
		// Let the monitor finish the last compare before the verdict
		@(negedge clk_sys);
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk_sys);
		errors++;
		wrap_up();
	end
endmodule

// >>> verif/mes_irq_props.sv
// Checker of summary, interrupt and flag-hold relations on the event interface
module mes_irq_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic [31:0] status,
	input wire logic [31:0] enable_wr,
	input wire logic enable_we,
	input wire logic [31:0] enable,
	input wire logic tx_irq,
	input wire logic rx_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Flags set now that no write of one is clearing
	logic [31:0] keep_m;
	assign keep_m = status & mes_pkg::FLAG_MASK & ~(wr_en ? wr_data : 32'h0000_0000);
	sequence en_load_s;
		enable_we;
	endsequence
	sequence flag_kept_s;
		keep_m != 32'h0000_0000;
	endsequence
	tx_sum_a: assert property (status[16] == |(status & enable & mes_pkg::TX_SRC_MASK))
		else $error("transmit summary wrong");
	rx_sum_a: assert property (status[0] == |(status & enable & mes_pkg::RX_SRC_MASK))
		else $error("receive summary wrong");
	tx_gate_a: assert property (tx_irq == (status[16] && enable[16]))
		else $error("transmit interrupt gating wrong");
	rx_gate_a: assert property (rx_irq == (status[0] && enable[0]))
		else $error("receive interrupt gating wrong");
	flag_hold_a: assert property (flag_kept_s |=> ((status & $past(keep_m)) == $past(keep_m)))
		else $error("flag lost without a clear");
	unused_zero_a: assert property ((status & ~(mes_pkg::FLAG_MASK | 32'h0001_0001)) == 32'h0000_0000)
		else $error("unused status bit set");
	en_load_a: assert property (en_load_s |=> enable == $past(enable_wr))
		else $error("enable not loaded");
	en_hold_a: assert property (!enable_we |=> $stable(enable))
		else $error("enable changed without write");
	under_irq_a: assert property ($rose(status[17]) && enable[17] && enable[16] |-> tx_irq)
		else $error("underflow did not interrupt");
endmodule
